// ### rtl/tsec_pkg.sv
package tsec_pkg;

	localparam int unsigned TSEC_CLK_HZ = 40_000_000;
	localparam int unsigned TSEC_TURN_MS = 205;
	localparam int unsigned TSEC_TURN_CYCLES = TSEC_TURN_MS * (TSEC_CLK_HZ / 1000);
	localparam int unsigned TSEC_OVR_NS = 2000;
	localparam int unsigned TSEC_OVR_CYCLES = (TSEC_OVR_NS * 40) / 1000;

	localparam logic [3:0] TSEC_OFS_STATUS = 4'h0;
	localparam logic [3:0] TSEC_OFS_SENSE = 4'h4;
	localparam logic [3:0] TSEC_OFS_MODE = 4'h8;
	localparam logic [3:0] TSEC_OFS_TURN = 4'hC;

	// Status bit positions
	localparam int TSEC_ST_SM = 1;
	localparam int TSEC_ST_CUE = 2;
	localparam int TSEC_ST_BUSY = 3;
	localparam int TSEC_ST_CE = 4;
	localparam int TSEC_ST_DE = 5;
	localparam int TSEC_ST_UC = 6;
	localparam int TSEC_ST_UE = 7;

	// Sense bit positions (byte/bit)
	localparam int TSEC_S0_REJ = 0;
	localparam int TSEC_S0_BUSOUT = 2;
	localparam int TSEC_S0_EQUIP = 3;
	localparam int TSEC_S0_DATA = 4;
	localparam int TSEC_S0_OVR = 5;
	localparam int TSEC_S0_WCZ = 6;
	localparam int TSEC_S1_GAP = 0;
	localparam int TSEC_S3_DREG = 0;
	localparam int TSEC_S3_LRC = 1;
	localparam int TSEC_S3_SKEW = 2;
	localparam int TSEC_S3_RREG = 4;
	localparam int TSEC_S3_CMP = 7;

	// Mode register fields
	localparam int TSEC_M_SEVEN = 0;
	localparam int TSEC_M_EVEN = 1;
	localparam int TSEC_M_XLATE = 2;
	localparam int TSEC_M_DCOPT = 3;
	localparam logic [3:0] TSEC_MODE_RST = 4'h0;

	typedef enum logic [3:0] {
		TSEC_CMD_TEST_IO = 4'h0,
		TSEC_CMD_READ = 4'h1,
		TSEC_CMD_READ_BWD = 4'h2,
		TSEC_CMD_WRITE = 4'h3,
		TSEC_CMD_WTM = 4'h4,
		TSEC_CMD_ERG = 4'h5,
		TSEC_CMD_SENSE = 4'h6,
		TSEC_CMD_CTRL = 4'h7,
		TSEC_CMD_FSB = 4'h8,
		TSEC_CMD_BSB = 4'h9,
		TSEC_CMD_DC_ON = 4'hA,
		TSEC_CMD_REW_UNL = 4'hB
	} tsec_cmd_type;

	typedef enum logic [0:0] {
		TSEC_TURN_IDLE = 1'b0,
		TSEC_TURN_WAIT = 1'b1
	} tsec_turn_type;

endpackage

// ### rtl/tsec_top.sv
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
// Functional notes
// [R01] Status byte on reject, selection end, unload, finish
// [R02] Bit 0 unused; modifier only with busy
// [R03] Control unit end after busy, check, exception
// [R04] Busy plus modifier: busy or other pending
// [R05] Busy alone: same-drive pending or rewinding
// [R06] Channel end: data commands done, control accepted
// [R07] Device end when drive completes command
// [R08] Device end on ready drop, later ready
// [R09] Unit check sources including nonexistent drive
// [R10] Unit exception: end-of-tape writes, tape mark
// [R11] Direction mismatch: change, brake, 205 ms delay
// [R12] Any error except gap noise gives check
// [R13] Data errors set sense 3 and data check
// [R14] Compare or counter check: equipment check
// [R15] Command reject: protected write, absent converter
// [R16] Bad parity: bus out check, blocks command
// [R17] Late service-out answer sets overrun
// [R18] Command out on first write: word count zero
// [R19] Gap noise inside the checked windows
// [R20] Read data vertical parity check by mode
// [R21] Longitudinal register must clear after check char
// [R22] Compare check off during seven-track translate
module tsec_top
	import tsec_pkg::*;
#(
	parameter int unsigned TURN_CYCLES = TSEC_TURN_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic i_cmd_valid,
	input wire logic [3:0] i_cmd_code,
	input wire logic i_cmd_parity_ok,
	input wire logic i_busy_other,
	input wire logic i_pending_other,
	input wire logic i_pending_same,
	input wire logic i_drive_exists,
	input wire logic i_drive_rewinding,
	input wire logic i_drive_ready,
	input wire logic i_file_protect,
	input wire logic i_eot_area,
	input wire logic i_op_end,
	input wire logic i_ready_drop,
	input wire logic i_bwd_at_lp,
	input wire logic i_rewunl_start,
	input wire logic i_rewunl_done,
	input wire logic i_tape_mark,
	input wire logic i_svc_in,
	input wire logic i_svc_out,
	input wire logic i_cmd_out,
	input wire logic i_wr_data_parity_err,
	input wire logic i_start_delay,
	input wire logic i_tape_moving,
	input wire logic i_stop_delay,
	input wire logic i_gap_bit,
	input wire logic i_dreg_valid,
	input wire logic [8:0] i_dreg_data,
	input wire logic i_longitudinal_check_character_done,
	input wire logic [8:0] i_lrc_reg,
	input wire logic i_skew_err,
	input wire logic i_rreg_err,
	input wire logic i_compare_err,
	input wire logic i_counter_check,
	input wire logic i_motion_start,
	input wire logic i_drive_fwd,
	output logic [7:0] o_status,
	output logic o_status_valid,
	output logic o_dir_change,
	output logic o_brake,
	output logic o_motion_go,
	output logic o_wcz_stop
);

	typedef struct packed {
		logic [7:0] status;
		logic st_valid;
		logic [7:0] sense0;
		logic [7:0] sense1;
		logic [7:0] sense3;
		logic [3:0] mode;
		tsec_cmd_type cmd;
		logic op_active;
		logic uc_pend;
		logic ue_pend;
		logic busy_seen;
		logic first_wr;
		logic svc_wait;
		logic [7:0] ovr_cnt;
		logic wait_ready;
		logic ready_prev;
		tsec_turn_type turn;
		logic [22:0] turn_cnt;
		logic brake;
		logic dir_chg;
		logic go;
		logic wcz_stop;
		logic ahb_wr;
		logic [3:0] ahb_ofs;
		logic [31:0] hrdata;
	} tsec_state_type;

	tsec_state_type q;
	tsec_state_type d;

	tsec_cmd_type cmd_in;
	logic is_ctrl_in;
	logic is_wrlike_in;
	logic is_wrlike;
	logic is_rd;
	logic is_ctrl;
	logic em;
	logic [7:0] sb;
	logic err;
	logic gap_win;
	logic par;
	logic par_bad;
	logic bwd;
	logic [31:0] rd;

	assign cmd_in = tsec_cmd_type'(i_cmd_code);
	assign is_ctrl_in = cmd_in inside {TSEC_CMD_WTM, TSEC_CMD_ERG,
		TSEC_CMD_CTRL, TSEC_CMD_FSB, TSEC_CMD_BSB, TSEC_CMD_DC_ON,
		TSEC_CMD_REW_UNL};
	assign is_wrlike_in = cmd_in inside {TSEC_CMD_WRITE, TSEC_CMD_WTM,
		TSEC_CMD_ERG};
	assign is_wrlike = q.cmd inside {TSEC_CMD_WRITE, TSEC_CMD_WTM,
		TSEC_CMD_ERG};
	assign is_rd = q.cmd inside {TSEC_CMD_READ, TSEC_CMD_READ_BWD};
	assign is_ctrl = q.cmd inside {TSEC_CMD_WTM, TSEC_CMD_ERG,
		TSEC_CMD_CTRL, TSEC_CMD_FSB, TSEC_CMD_BSB, TSEC_CMD_DC_ON,
		TSEC_CMD_REW_UNL};
	assign bwd = q.cmd inside {TSEC_CMD_READ_BWD, TSEC_CMD_BSB};

	always_comb begin
		d = q;
		em = 1'b0;
		sb = 8'h00;
		err = 1'b0;
		d.st_valid = 1'b0;
		d.dir_chg = 1'b0;
		d.go = 1'b0;
		d.wcz_stop = 1'b0;
		d.ready_prev = i_drive_ready;

		// Software writes first so that hardware sets below win
		if (q.ahb_wr) begin
			case (q.ahb_ofs)
				TSEC_OFS_SENSE: begin
					d.sense0 = q.sense0 & ~i_hwdata[7:0];
					d.sense1 = q.sense1 & ~i_hwdata[15:8];
					d.sense3 = q.sense3 & ~i_hwdata[23:16];
				end
				TSEC_OFS_MODE: begin
					d.mode = i_hwdata[3:0];
				end
				default: begin
				end
			endcase
		end
		case (i_haddr[3:0])
			TSEC_OFS_STATUS: rd = {24'h000000, q.status};
			TSEC_OFS_SENSE: rd = {8'h00, q.sense3, q.sense1, q.sense0};
			TSEC_OFS_MODE: rd = {28'h0000000, q.mode};
			TSEC_OFS_TURN: rd = {8'h00, q.turn == TSEC_TURN_WAIT,
				q.turn_cnt};
			default: rd = 32'h00000000;
		endcase
		d.ahb_wr = 1'b0;
		if (i_hsel && i_hready && i_htrans[1]) begin
			d.ahb_ofs = i_haddr[3:0];
			d.ahb_wr = i_hwrite && (i_haddr[31:4] == 28'h0000000);
			if (!i_hwrite) begin
				d.hrdata = (i_haddr[31:4] == 28'h0000000) ? rd :
					32'h00000000;
			end
		end

		// Overrun watchdog on each service-in
		if (i_svc_in) begin
			d.svc_wait = 1'b1;
			d.ovr_cnt = 8'h00;
		end else if (q.svc_wait) begin
			if (i_svc_out || i_cmd_out) begin
				d.svc_wait = 1'b0;
			end else if (q.ovr_cnt == TSEC_OVR_CYCLES[7:0] - 8'h01) begin
				d.svc_wait = 1'b0;
				d.sense0[TSEC_S0_OVR] = 1'b1; // [R17]
				err = 1'b1;
			end else begin
				d.ovr_cnt = q.ovr_cnt + 8'h01;
			end
		end
		if (i_svc_out) begin
			d.first_wr = 1'b0;
		end
		if (i_wr_data_parity_err && q.op_active) begin
			d.sense0[TSEC_S0_BUSOUT] = 1'b1; // [R16]
			err = 1'b1;
		end

		gap_win = ((q.cmd == TSEC_CMD_WRITE || q.cmd == TSEC_CMD_WTM) &&
			i_start_delay) || (q.cmd == TSEC_CMD_ERG && i_tape_moving &&
			!i_stop_delay);
		if (q.op_active && gap_win && i_gap_bit) begin
			d.sense1[TSEC_S1_GAP] = 1'b1; // [R19]
		end

		// Seven-track parity covers six data bits plus P
		par = q.mode[TSEC_M_SEVEN] ? ^{i_dreg_data[8], i_dreg_data[5:0]} :
			^i_dreg_data;
		par_bad = (q.mode[TSEC_M_SEVEN] && q.mode[TSEC_M_EVEN]) ? par : !par;
		if (q.op_active && is_rd && i_dreg_valid && par_bad) begin
			d.sense3[TSEC_S3_DREG] = 1'b1; // [R20]
			d.sense0[TSEC_S0_DATA] = 1'b1; // [R13]
			err = 1'b1;
		end
		if (q.op_active && i_longitudinal_check_character_done && (i_lrc_reg != 9'h000) &&
			(is_rd || q.cmd == TSEC_CMD_WRITE || q.cmd == TSEC_CMD_WTM)) begin
			d.sense3[TSEC_S3_LRC] = 1'b1; // [R21]
			d.sense0[TSEC_S0_DATA] = 1'b1; // [R13]
			err = 1'b1;
		end
		if (i_skew_err || i_rreg_err) begin
			d.sense3[TSEC_S3_SKEW] = q.sense3[TSEC_S3_SKEW] | i_skew_err;
			d.sense3[TSEC_S3_RREG] = q.sense3[TSEC_S3_RREG] | i_rreg_err;
			d.sense0[TSEC_S0_DATA] = 1'b1; // [R13]
			err = 1'b1;
		end
		if (i_compare_err &&
			!(q.mode[TSEC_M_SEVEN] && q.mode[TSEC_M_XLATE])) begin // [R22]
			d.sense3[TSEC_S3_CMP] = 1'b1;
			d.sense0[TSEC_S0_EQUIP] = 1'b1; // [R14]
			err = 1'b1;
		end
		if (i_counter_check) begin
			d.sense0[TSEC_S0_EQUIP] = 1'b1; // [R14]
			err = 1'b1;
		end
		if (q.op_active && i_tape_mark && (is_rd ||
			q.cmd == TSEC_CMD_FSB || q.cmd == TSEC_CMD_BSB)) begin
			d.ue_pend = 1'b1; // [R10]
		end
		if (q.op_active && is_wrlike && i_eot_area && i_tape_moving) begin
			d.ue_pend = 1'b1; // [R10]
		end
		if (err) begin
			d.uc_pend = 1'b1; // [R12]
		end

		// Status byte sources, selection has priority
		if (i_cmd_valid) begin
			em = 1'b1; // [R01]
			if (i_busy_other || i_pending_other) begin
				sb[TSEC_ST_BUSY] = 1'b1; // [R04]
				sb[TSEC_ST_SM] = 1'b1; // [R02]
				d.busy_seen = q.op_active;
			end else if (!i_drive_exists) begin
				sb[TSEC_ST_UC] = 1'b1; // [R09]
			end else if (i_drive_rewinding ||
				(i_pending_same && cmd_in != TSEC_CMD_TEST_IO)) begin
				sb[TSEC_ST_BUSY] = 1'b1; // [R05]
			end else if (!i_cmd_parity_ok) begin
				d.sense0 = 8'h00;
				d.sense0[TSEC_S0_BUSOUT] = 1'b1; // [R16]
				sb[TSEC_ST_UC] = 1'b1;
			end else if ((is_wrlike_in && i_file_protect) ||
				(cmd_in == TSEC_CMD_DC_ON && !q.mode[TSEC_M_DCOPT])) begin
				d.sense0 = 8'h00;
				d.sense0[TSEC_S0_REJ] = 1'b1; // [R15]
				sb[TSEC_ST_UC] = 1'b1;
			end else begin
				if (cmd_in != TSEC_CMD_SENSE && cmd_in != TSEC_CMD_TEST_IO) begin
					d.sense0 = 8'h00;
					d.sense1 = 8'h00;
					d.sense3 = 8'h00;
				end
				if (cmd_in != TSEC_CMD_TEST_IO) begin
					d.cmd = cmd_in;
					d.op_active = !is_ctrl_in || cmd_in != TSEC_CMD_DC_ON;
					d.busy_seen = 1'b0;
					d.ue_pend = 1'b0;
					d.first_wr = cmd_in == TSEC_CMD_WRITE;
				end
				d.wait_ready = !i_drive_ready;
				sb[TSEC_ST_CE] = is_ctrl_in; // [R06]
				sb[TSEC_ST_UC] = q.uc_pend;
			end
		end else if (q.op_active && q.first_wr && q.svc_wait && i_cmd_out) begin
			d.sense0[TSEC_S0_WCZ] = 1'b1; // [R18]
			d.wcz_stop = 1'b1;
			d.first_wr = 1'b0;
			d.op_active = 1'b0;
			em = 1'b1;
			sb[TSEC_ST_CE] = 1'b1;
			sb[TSEC_ST_DE] = 1'b1;
			sb[TSEC_ST_UC] = 1'b1;
			sb[TSEC_ST_CUE] = 1'b1; // [R03]
		end else if (q.op_active && (i_ready_drop || (i_bwd_at_lp && bwd))) begin
			em = 1'b1;
			d.op_active = 1'b0;
			sb[TSEC_ST_CE] = 1'b1; // [R08]
			sb[TSEC_ST_DE] = 1'b1;
			sb[TSEC_ST_UC] = 1'b1; // [R09]
			sb[TSEC_ST_CUE] = 1'b1; // [R03]
			sb[TSEC_ST_UE] = q.ue_pend;
		end else if (q.op_active && i_op_end) begin
			em = 1'b1; // [R01]
			d.op_active = 1'b0;
			sb[TSEC_ST_CE] = !is_ctrl; // [R06]
			sb[TSEC_ST_DE] = 1'b1; // [R07]
			sb[TSEC_ST_UC] = q.uc_pend | err;
			sb[TSEC_ST_UE] = q.ue_pend; // [R10]
			sb[TSEC_ST_CUE] = q.busy_seen | q.uc_pend | err |
				q.ue_pend; // [R03]
		end else if (i_rewunl_start) begin
			em = 1'b1; // [R01]
			d.op_active = 1'b0;
			d.wait_ready = 1'b1;
			sb[TSEC_ST_CE] = 1'b1;
		end else if (i_rewunl_done) begin
			em = 1'b1;
			sb[TSEC_ST_DE] = 1'b1; // [R07]
			sb[TSEC_ST_UC] = 1'b1; // [R09]
		end else if (q.wait_ready && i_drive_ready && !q.ready_prev) begin
			em = 1'b1;
			d.wait_ready = 1'b0;
			sb[TSEC_ST_DE] = 1'b1; // [R08]
		end
		if (em) begin
			// Sense byte 0 except equipment check forces unit check
			sb[TSEC_ST_UC] = sb[TSEC_ST_UC] |
				(|(d.sense0 & ~(8'h01 << TSEC_S0_EQUIP))); // [R09]
			sb[0] = 1'b0; // [R02]
			d.status = sb;
			d.st_valid = 1'b1;
			if (sb[TSEC_ST_UC] && !err) begin
				d.uc_pend = 1'b0; // [R12]
			end
		end

		// Turnaround holds motion until the capstan reverses
		case (q.turn)
			TSEC_TURN_IDLE: begin
				if (i_motion_start) begin
					if (i_drive_fwd == bwd) begin
						d.dir_chg = 1'b1; // [R11]
						d.brake = 1'b1;
						d.turn_cnt = 23'h000000;
						d.turn = TSEC_TURN_WAIT;
					end else begin
						d.go = 1'b1;
					end
				end
			end
			TSEC_TURN_WAIT: begin
				if (q.turn_cnt == 23'(TURN_CYCLES - 1)) begin
					d.brake = 1'b0; // [R11]
					d.go = 1'b1;
					d.turn = TSEC_TURN_IDLE;
				end else begin
					d.turn_cnt = q.turn_cnt + 23'h000001;
				end
			end
			default: begin
				d.turn = TSEC_TURN_IDLE;
			end
		endcase
	end

	// Clock enable low freezes the bus slave as well
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '{status: 8'h00, st_valid: 1'b0, sense0: 8'h00,
				sense1: 8'h00, sense3: 8'h00, mode: TSEC_MODE_RST,
				cmd: TSEC_CMD_TEST_IO, op_active: 1'b0, uc_pend: 1'b0,
				ue_pend: 1'b0, busy_seen: 1'b0, first_wr: 1'b0,
				svc_wait: 1'b0, ovr_cnt: 8'h00, wait_ready: 1'b0,
				ready_prev: 1'b0, turn: TSEC_TURN_IDLE,
				turn_cnt: 23'h000000, brake: 1'b0, dir_chg: 1'b0,
				go: 1'b0, wcz_stop: 1'b0, ahb_wr: 1'b0, ahb_ofs: 4'h0,
				hrdata: 32'h00000000};
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = q.hrdata;
	assign o_status = q.status;
	assign o_status_valid = q.st_valid;
	assign o_dir_change = q.dir_chg;
	assign o_brake = q.brake;
	assign o_motion_go = q.go;
	assign o_wcz_stop = q.wcz_stop;

endmodule // tsec_top

// ### testbench/tsec_properties.sv
`timescale 1ns/10ps
module tsec_checker
	import tsec_pkg::*;
#(
	parameter int unsigned TURN_CYCLES = 20
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_cmd_valid,
	input wire logic [3:0] i_cmd_code,
	input wire logic i_cmd_parity_ok,
	input wire logic i_busy_other,
	input wire logic i_pending_other,
	input wire logic i_pending_same,
	input wire logic i_drive_exists,
	input wire logic i_drive_rewinding,
	input wire logic [7:0] o_status,
	input wire logic o_status_valid,
	input wire logic o_dir_change,
	input wire logic o_brake,
	input wire logic o_motion_go,
	input wire logic o_wcz_stop
);
	logic [31:0] brk_q;
	logic [31:0] brk_d;
	logic sel;
	logic idle;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	assign sel = i_cmd_valid && i_ce;
	assign idle = !i_busy_other && !i_pending_other;
	// Brake time is far too long to unroll, so it is counted here
	always_comb brk_d = o_brake ? brk_q + 32'h1 : 32'h0;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			brk_q <= 32'h0;
		end else if (i_ce) begin
			brk_q <= brk_d;
		end
	end
	a_bit0_unused: assert property (o_status_valid |-> !o_status[0])
		else $error("status bit 0 set");
	a_modifier_busy: assert property (o_status_valid && o_status[1] |-> o_status[3])
		else $error("modifier without busy");
	a_select_status: assert property (sel |=> o_status_valid)
		else $error("no status after selection");
	a_short_busy: assert property (sel && i_busy_other |=> o_status[3] && o_status[1])
		else $error("short busy wrong");
	a_long_busy: assert property (sel && idle && i_drive_exists && (i_drive_rewinding
		|| i_pending_same && i_cmd_code != TSEC_CMD_TEST_IO)
		|=> o_status[3] && !o_status[1])
		else $error("long busy wrong");
	a_no_drive: assert property (sel && idle && !i_drive_exists |=> o_status[6])
		else $error("missing drive without check");
	a_bus_out: assert property (sel && idle && i_drive_exists && !i_drive_rewinding
		&& !(i_pending_same && i_cmd_code != TSEC_CMD_TEST_IO)
		&& !i_cmd_parity_ok
		|=> o_status[6] && !o_status[4])
		else $error("bad command parity accepted");
	a_turn_start: assert property ($rose(o_brake) |-> o_dir_change)
		else $error("brake without direction change");
	a_brake_hold: assert property (o_dir_change |=> o_brake [*3])
		else $error("brake released early");
	a_turn_len: assert property ($fell(o_brake)
		|-> o_motion_go && brk_q == TURN_CYCLES)
		else $error("turnaround length wrong");
	a_wcz_stop: assert property (o_wcz_stop |-> o_status_valid && o_status[6])
		else $error("word count stop without check");
endmodule // tsec_checker
bind tsec_top tsec_checker #(.TURN_CYCLES(TURN_CYCLES)) tsec_checker_i (.*);

// ### testbench/tsec_chan_model.sv
`timescale 1ns/10ps
module tsec_chan_model (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_svc_in,
	input wire logic i_stop,
	input wire logic [7:0] i_dly,
	output logic o_svc_out,
	output logic o_cmd_out
);
	logic [7:0] cnt;
	// Answer delay is free so that a late reply can provoke overrun
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 8'h0;
			o_svc_out <= 1'b0;
			o_cmd_out <= 1'b0;
		end else begin
			o_svc_out <= cnt == 8'h1 && !i_stop;
			o_cmd_out <= cnt == 8'h1 && i_stop;
			if (i_svc_in) begin
				cnt <= i_dly;
			end else if (cnt != 8'h0) begin
				cnt <= cnt - 8'h1;
			end
		end
	end
endmodule // tsec_chan_model

// ### testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top
	import tsec_pkg::*;
;
	localparam int unsigned TC = 20;
	logic i_core_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_hsel = 1'b0;
	logic i_hwrite = 1'b0, i_cmd_valid = 1'b0, stop = 1'b0;
	logic [1:0] i_htrans = 2'h0;
	logic [2:0] i_hsize = 3'h2;
	logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
	logic [3:0] i_cmd_code = 4'h0;
	logic i_cmd_parity_ok = 1'b1, i_busy_other = 1'b0, i_pending_other = 1'b0;
	logic i_pending_same = 1'b0, i_drive_exists = 1'b1, i_drive_rewinding = 1'b0;
	logic i_file_protect = 1'b0;
	logic [8:0] i_dreg_data = 9'h0, i_lrc_reg = 9'h0;
	logic [15:0] ev = 16'h0;
	logic [5:0] lv = 6'h01;
	logic [7:0] dly = 8'h3, o_status;
	logic [16:0] sd = 17'h13683;
	logic [7:0] q[$];
	int error_cnt = 0, n_tests = 0, cyc = 0;
	logic o_hreadyout, o_hresp, o_status_valid, o_dir_change, o_brake;
	logic o_motion_go, o_wcz_stop, i_svc_out, i_cmd_out;
	wire logic i_hready, i_op_end, i_ready_drop, i_bwd_at_lp, i_rewunl_start;
	wire logic i_rewunl_done, i_tape_mark, i_svc_in, i_wr_data_parity_err;
	wire logic i_gap_bit, i_dreg_valid, i_longitudinal_check_character_done, i_skew_err, i_rreg_err;
	wire logic i_compare_err, i_counter_check, i_motion_start, i_drive_fwd;
	wire logic i_start_delay, i_tape_moving, i_eot_area, i_stop_delay;
	wire logic i_drive_ready;
	assign i_hready = o_hreadyout;
	assign {i_motion_start, i_counter_check, i_compare_err, i_rreg_err,
		i_skew_err, i_longitudinal_check_character_done, i_dreg_valid, i_gap_bit, i_wr_data_parity_err,
		i_svc_in, i_tape_mark, i_rewunl_done, i_rewunl_start, i_bwd_at_lp,
		i_ready_drop, i_op_end} = ev;
	assign {i_drive_fwd, i_start_delay, i_tape_moving, i_eot_area,
		i_stop_delay, i_drive_ready} = lv;
	tsec_top #(.TURN_CYCLES(TC)) tsec_top_i (.*);
	tsec_chan_model tsec_chan_model_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_svc_in(i_svc_in), .i_stop(stop), .i_dly(dly),
		.o_svc_out(i_svc_out), .o_cmd_out(i_cmd_out));
	always #12.5 i_core_clk = ~i_core_clk;
	function automatic logic [16:0] nxt(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic wrap_up();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, s);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= a;
		i_hwrite <= w;
		do @(posedge i_core_clk); while (i_hready !== 1'b1);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_core_clk); while (i_hready !== 1'b1);
		r = o_hrdata;
	endtask
	task automatic rd(input logic [31:0] a, e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk("register", e, r);
		chk("hresp", 32'h0, {31'h0, o_hresp});
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic cmd(input tsec_cmd_type c, input logic [6:0] f,
		input logic [7:0] e);
		q.push_back(e);
		i_cmd_code <= c;
		{i_cmd_parity_ok, i_busy_other, i_pending_other, i_pending_same,
			i_drive_exists, i_drive_rewinding, i_file_protect} <= 7'h44 ^ f;
		i_cmd_valid <= 1'b1;
		@(posedge i_core_clk);
		i_cmd_valid <= 1'b0;
		repeat (3) @(posedge i_core_clk);
	endtask
	// Pulse gap avoids two drives of ev in one time step
	task automatic ev_p(input logic [15:0] m);
		sd = nxt(sd);
		i_dreg_data <= {^sd[5:0], 2'h0, sd[5:0]};
		i_lrc_reg <= {1'b1, sd[7:0]};
		ev <= m;
		@(posedge i_core_clk);
		ev <= 16'h0;
		@(posedge i_core_clk);
	endtask
	task automatic run(input tsec_cmd_type c, input logic [5:0] l,
		input logic [15:0] m, input logic [31:0] s, input logic [7:0] e);
		lv <= l;
		cmd(c, 7'h0, 8'h00);
		q.push_back(e);
		ev_p(m);
		repeat (100) @(posedge i_core_clk);
		ev_p(16'h1);
		rd(32'h4, s);
		lv <= 6'h01;
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (o_status_valid === 1'b1) begin
			chk("status", q.size() ? {24'h0, q.pop_front()} : 32'hFFFFFFFF,
				{24'h0, o_status});
		end
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(posedge i_core_clk);
		rd(32'h8, 32'h0);
		wr(32'h10, {15'h0, sd});
		rd(32'h10, 32'h0);
		run(TSEC_CMD_READ, 6'h01, 16'h0200, 32'h00010010, 8'h74);
		wr(32'h8, 32'h3);
		rd(32'h8, 32'h3);
		run(TSEC_CMD_READ, 6'h01, 16'h0200, 32'h0, 8'h30);
		wr(32'h8, 32'h5);
		run(TSEC_CMD_READ, 6'h01, 16'h2000, 32'h0, 8'h30);
		wr(32'h8, 32'h0);
		run(TSEC_CMD_READ, 6'h01, 16'h0400, 32'h00020010, 8'h74);
		run(TSEC_CMD_WRITE, 6'h01, 16'h0800, 32'h00040010, 8'h74);
		run(TSEC_CMD_WRITE, 6'h01, 16'h1000, 32'h00100010, 8'h74);
		run(TSEC_CMD_READ, 6'h01, 16'h2000, 32'h00800008, 8'h74);
		run(TSEC_CMD_WRITE, 6'h01, 16'h4000, 32'h00000008, 8'h74);
		run(TSEC_CMD_WRITE, 6'h01, 16'h0080, 32'h00000004, 8'h74);
		run(TSEC_CMD_WRITE, 6'h11, 16'h0100, 32'h00000100, 8'h30);
		run(TSEC_CMD_WRITE, 6'h0D, 16'h0, 32'h0, 8'hB4);
		run(TSEC_CMD_READ, 6'h01, 16'h0020, 32'h0, 8'hB4);
		run(TSEC_CMD_READ, 6'h09, 16'h0002, 32'h0, 8'h74);
		run(TSEC_CMD_READ_BWD, 6'h01, 16'h0004, 32'h0, 8'h74);
		run(TSEC_CMD_READ, 6'h01, 16'h0040, 32'h0, 8'h30);
		dly <= 8'd100;
		run(TSEC_CMD_READ, 6'h01, 16'h0040, 32'h00000020, 8'h74);
		wr(32'h4, 32'hFFFFFFFF);
		rd(32'h4, 32'h0);
		stop <= 1'b1;
		dly <= 8'h3;
		run(TSEC_CMD_WRITE, 6'h01, 16'h0040, 32'h00000040, 8'h74);
		stop <= 1'b0;
		rd(32'h0, 32'h74);
		wr(32'h4, 32'hFFFFFFFF);
		cmd(TSEC_CMD_READ, 7'h20, 8'h0A);
		cmd(TSEC_CMD_READ, 7'h10, 8'h0A);
		cmd(TSEC_CMD_READ, 7'h08, 8'h08);
		cmd(TSEC_CMD_TEST_IO, 7'h02, 8'h08);
		cmd(TSEC_CMD_READ, 7'h04, 8'h40);
		cmd(TSEC_CMD_READ, 7'h40, 8'h40);
		rd(32'h4, 32'h04);
		cmd(TSEC_CMD_WRITE, 7'h01, 8'h40);
		rd(32'h4, 32'h01);
		cmd(TSEC_CMD_DC_ON, 7'h0, 8'h40);
		rd(32'h4, 32'h01);
		cmd(TSEC_CMD_CTRL, 7'h0, 8'h10);
		q.push_back(8'h20);
		ev_p(16'h1);
		cmd(TSEC_CMD_READ, 7'h0, 8'h00);
		cmd(TSEC_CMD_READ, 7'h20, 8'h0A);
		q.push_back(8'h34);
		ev_p(16'h1);
		lv <= 6'h21;
		cmd(TSEC_CMD_READ_BWD, 7'h0, 8'h00);
		ev_p(16'h8000);
		repeat (TC + 2) @(posedge i_core_clk);
		chk("brake", 32'h0, {31'h0, o_brake});
		q.push_back(8'h30);
		ev_p(16'h1);
		cmd(TSEC_CMD_READ, 7'h0, 8'h00);
		ev_p(16'h8000);
		chk("motion go", 32'h1, {31'h0, o_motion_go});
		q.push_back(8'h30);
		ev_p(16'h1);
		repeat (4) @(posedge i_core_clk);
		chk("queue", 32'h0, q.size());
		wrap_up();
	end
endmodule // tb_top
